// file: src/tic_pkg.sv
package tic_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_PRELOAD  = 8'h04;
   localparam logic [7:0] OFF_PERIOD   = 8'h08;
   localparam logic [7:0] OFF_AUX      = 8'h0C;
   localparam logic [7:0] OFF_COUNTER  = 8'h10;
   localparam logic [7:0] OFF_SNAPSHOT = 8'h14;
   localparam logic [7:0] OFF_STATUS   = 8'h18;
   localparam logic [7:0] OFF_MASK     = 8'h1C;

   // control register fields
   localparam int CTRL_RUN_BIT   = 0;
   localparam int CTRL_SRC_LSB   = 1;
   localparam int CTRL_SRC_MSB   = 3;
   localparam int CTRL_CLRSEL_BIT = 4;
   localparam int CTRL_IRQSEL_BIT = 5;
   localparam int CTRL_WIDTH     = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;

   // status / mask layout
   localparam int ST_PERIOD_BIT = 0;
   localparam int ST_AUX_BIT    = 1;
   localparam int ST_WIDTH      = 2;
   localparam logic [1:0] ST_RESET   = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;

   localparam logic [15:0] CNT_RESET    = 16'h0000;
   localparam logic [15:0] CNT_FULL     = 16'hFFFF;
   localparam logic [15:0] CMP_ZERO     = 16'h0000;
   localparam logic [15:0] CMP_ONE      = 16'h0001;
   localparam logic [15:0] CMP_RESET    = 16'hFFFF;

   // count clock source select: bit 2 picks half-rate system clock, bits 1:0 the divider
   localparam int SRC_SYS_BIT = 2;
   localparam logic [1:0] DIV_1  = 2'h0;
   localparam logic [1:0] DIV_2  = 2'h1;
   localparam logic [1:0] DIV_4  = 2'h2;
   localparam logic [1:0] DIV_16 = 2'h3;
   localparam logic [3:0] MASK_DIV_1  = 4'h0;
   localparam logic [3:0] MASK_DIV_2  = 4'h1;
   localparam logic [3:0] MASK_DIV_4  = 4'h3;
   localparam logic [3:0] MASK_DIV_16 = 4'hF;

   localparam int CLK_SYS_PERIOD_NS = 100;
endpackage : tic_pkg

// file: src/tic_prescaler.sv
`timescale 1ns/1ps
module tic_prescaler (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic osc_in,
   tic_tick_if.pre   tk
);
   logic       osc_q;
   logic       osc_prev_q;
   logic       half_q;
   logic [3:0] div_q;
   logic [3:0] div_d;
   logic       tick_q;
   logic [3:0] div_mask;
   logic       osc_fall;
   logic       sys_fall;
   logic       base;
   logic       div_hit;

   // counting happens on falling edges of the chosen source
   assign osc_fall = osc_prev_q & ~osc_q;
   assign sys_fall = half_q;
   assign base     = tk.src_sel[tic_pkg::SRC_SYS_BIT] ? sys_fall : osc_fall;
   assign div_mask = (tk.src_sel[1:0] == tic_pkg::DIV_1)  ? tic_pkg::MASK_DIV_1 :
                     (tk.src_sel[1:0] == tic_pkg::DIV_2)  ? tic_pkg::MASK_DIV_2 :
                     (tk.src_sel[1:0] == tic_pkg::DIV_4)  ? tic_pkg::MASK_DIV_4 :
                                                            tic_pkg::MASK_DIV_16;
   assign div_hit  = base & ((div_q & div_mask) == div_mask);
   assign div_d    = tk.run ? (base ? div_q + 4'h1 : div_q) : 4'h0;
   assign tk.tick  = tick_q;

   // tick is a one-cycle enable so the core stays on clk_sys
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         osc_q      <= 1'b0;
         osc_prev_q <= 1'b0;
         half_q     <= 1'b0;
         div_q      <= 4'h0;
         tick_q     <= 1'b0;
      end else begin
         osc_q      <= osc_in;
         osc_prev_q <= osc_q;
         half_q     <= ~half_q;
         div_q      <= div_d;
         tick_q     <= tk.run & div_hit;
      end
   end

   chk_tick_one_cycle: assert property (
      @(posedge clk_sys) disable iff (rst)
      tick_q |=> !tick_q)
      else $error("count tick lasted more than one cycle");
endmodule : tic_prescaler

// file: src/tic_tick_if.sv
`timescale 1ns/1ps
interface tic_tick_if;
   logic [2:0] src_sel;
   logic       run;
   logic       tick;
   modport core (output src_sel, output run, input tick);
   modport pre  (input src_sel, input run, output tick);
endinterface : tic_tick_if

// file: src/tic_timer16.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
//  Contract
// - eight count sources: oscillator or half-rate system clock, divided 1, 2, 4, 16
// - up counter advances by one per selected count tick
// - preload write while stopped loads period compare and zeroes counter same cycle
// - counting only while run flag set, on count clock falling edge
// - preload write while running leaves counter untouched
// - on match, next tick reloads compare, sets flag, clears counter, keeps counting
// - clearing run flag stops counter and holds its value
// - period compare values zero and one give identical interrupt timing
// - two select flags choose match or overflow for interrupt and clear; clear on match also forces interrupt on match
// - aux compare match raises its own interrupt; clear follows chosen source
// - writing snapshot register captures the live counter value
module tic_timer16 (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        osc_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq
);
   logic [5:0]  ctrl_q;
   logic [5:0]  ctrl_d;
   logic [15:0] preload_q;
   logic [15:0] preload_d;
   logic [15:0] period_q;
   logic [15:0] period_d;
   logic [15:0] aux_q;
   logic [15:0] aux_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] snap_q;
   logic [15:0] snap_d;
   logic [1:0]  status_q;
   logic [1:0]  status_d;
   logic [1:0]  mask_q;
   logic [1:0]  mask_d;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic        irq_q;

   // bus decode
   logic        setup;
   logic        access;
   logic        wr_en;
   logic        sel_ctrl;
   logic        sel_preload;
   logic        sel_period;
   logic        sel_aux;
   logic        sel_counter;
   logic        sel_snapshot;
   logic        sel_status;
   logic        sel_mask;
   logic        mapped;
   logic [31:0] rd_mux;

   // timer core
   logic        run;
   logic        clear_select;
   logic        irq_select;
   logic        tick;
   logic        step;
   logic [15:0] period_eff;
   logic        match_period;
   logic        match_aux;
   logic        overflow;
   logic        clr_hit;
   logic        irq_hit;
   logic        preload_wr;
   logic        preload_wr_stopped;
   logic        snap_wr;
   logic [1:0]  events;
   logic [1:0]  w1c;

   tic_tick_if tk ();

   tic_prescaler u_prescaler (
      .clk_sys (clk_sys),
      .rst     (rst),
      .osc_in  (osc_in),
      .tk      (tk)
   );

   assign run          = ctrl_q[tic_pkg::CTRL_RUN_BIT];
   assign clear_select = ctrl_q[tic_pkg::CTRL_CLRSEL_BIT];
   assign irq_select   = ctrl_q[tic_pkg::CTRL_IRQSEL_BIT];
   assign tk.src_sel   = ctrl_q[tic_pkg::CTRL_SRC_MSB:tic_pkg::CTRL_SRC_LSB];
   assign tk.run       = run;
   assign tick         = tk.tick;
   assign step         = tick & run;

   assign setup        = psel & ~penable;
   assign access       = psel & penable & pready_q;
   assign wr_en        = access & pwrite;
   assign sel_ctrl     = paddr == tic_pkg::OFF_CTRL;
   assign sel_preload  = paddr == tic_pkg::OFF_PRELOAD;
   assign sel_period   = paddr == tic_pkg::OFF_PERIOD;
   assign sel_aux      = paddr == tic_pkg::OFF_AUX;
   assign sel_counter  = paddr == tic_pkg::OFF_COUNTER;
   assign sel_snapshot = paddr == tic_pkg::OFF_SNAPSHOT;
   assign sel_status   = paddr == tic_pkg::OFF_STATUS;
   assign sel_mask     = paddr == tic_pkg::OFF_MASK;
   assign mapped       = sel_ctrl | sel_preload | sel_period | sel_aux |
                         sel_counter | sel_snapshot | sel_status | sel_mask;

   assign rd_mux = sel_ctrl     ? {26'h000_0000, ctrl_q}   :
                   sel_preload  ? {16'h0000, preload_q}    :
                   sel_period   ? {16'h0000, period_q}     :
                   sel_aux      ? {16'h0000, aux_q}        :
                   sel_counter  ? {16'h0000, cnt_q}        :
                   sel_snapshot ? {16'h0000, snap_q}       :
                   sel_status   ? {30'h0000_0000, status_q} :
                   sel_mask     ? {30'h0000_0000, mask_q}   :
                                  32'h0000_0000;

   assign preload_wr         = wr_en & sel_preload;
   assign preload_wr_stopped = preload_wr & ~run;
   assign snap_wr            = wr_en & sel_snapshot & pstrb[0];

   // a zero compare behaves as one so both give the same request waveform
   assign period_eff   = (period_q == tic_pkg::CMP_ZERO) ? tic_pkg::CMP_ONE : period_q;
   assign match_period = cnt_q == period_eff;
   assign match_aux    = cnt_q == aux_q;
   assign overflow     = cnt_q == tic_pkg::CNT_FULL;
   assign clr_hit      = clear_select ? match_period : overflow;
   assign irq_hit      = (clear_select | irq_select) ? match_period : overflow;

   // match seen on the current value acts on the next tick
   assign events[tic_pkg::ST_PERIOD_BIT] = step & irq_hit;
   assign events[tic_pkg::ST_AUX_BIT]    = step & match_aux;
   assign w1c = (wr_en & sel_status & pstrb[0]) ? pwdata[1:0] : 2'h0;

   // set wins over a clear arriving in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < tic_pkg::ST_WIDTH; gi++) begin : g_status
         assign status_d[gi] = events[gi] | (status_q[gi] & ~w1c[gi]);
      end
   endgenerate

   assign ctrl_d = (wr_en & sel_ctrl & pstrb[0]) ? pwdata[5:0] : ctrl_q;
   assign mask_d = (wr_en & sel_mask & pstrb[0]) ? pwdata[1:0] : mask_q;
   assign aux_d  = (wr_en & sel_aux) ?
                   {pstrb[1] ? pwdata[15:8] : aux_q[15:8], pstrb[0] ? pwdata[7:0] : aux_q[7:0]} : aux_q;
   // byte halves land independently; software completes both before a reload
   assign preload_d = preload_wr ?
                   {pstrb[1] ? pwdata[15:8] : preload_q[15:8], pstrb[0] ? pwdata[7:0] : preload_q[7:0]} :
                   preload_q;
   assign snap_d = snap_wr ? cnt_q : snap_q;

   always_comb begin
      cnt_d    = cnt_q;
      period_d = period_q;
      if (step) begin
         if (clr_hit) begin
            cnt_d    = tic_pkg::CNT_RESET;
            period_d = preload_q;
         end else begin
            cnt_d = cnt_q + 16'h0001;
         end
      end
      if (preload_wr_stopped) begin
         period_d = preload_d;
         cnt_d    = tic_pkg::CNT_RESET;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q    <= tic_pkg::CTRL_RESET;
         preload_q <= tic_pkg::CMP_RESET;
         period_q  <= tic_pkg::CMP_RESET;
         aux_q     <= tic_pkg::CMP_RESET;
         cnt_q     <= tic_pkg::CNT_RESET;
         snap_q    <= tic_pkg::CNT_RESET;
         status_q  <= tic_pkg::ST_RESET;
         mask_q    <= tic_pkg::MASK_RESET;
      end else begin
         ctrl_q    <= ctrl_d;
         preload_q <= preload_d;
         period_q  <= period_d;
         aux_q     <= aux_d;
         cnt_q     <= cnt_d;
         snap_q    <= snap_d;
         status_q  <= status_d;
         mask_q    <= mask_d;
      end
   end

   // read data sampled in setup so the access phase finishes without wait
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q     <= 1'b0;
      end else begin
         prdata_q  <= (setup & ~pwrite) ? rd_mux : prdata_q;
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         irq_q     <= |(status_d & mask_d);
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign irq     = irq_q;

   chk_stop_load_clear: assert property (
      @(posedge clk_sys) disable iff (rst)
      preload_wr_stopped |=> (cnt_q == 16'h0000) && (period_q == preload_q))
      else $error("stopped preload write did not load compare and clear counter");

   chk_run_preload_keep: assert property (
      @(posedge clk_sys) disable iff (rst)
      (preload_wr && run && !step) |=> cnt_q == $past(cnt_q))
      else $error("running preload write disturbed the counter");

   chk_count_step_one: assert property (
      @(posedge clk_sys) disable iff (rst)
      (step && !clr_hit && !preload_wr_stopped) |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("counter did not advance by one on a tick");

   chk_stop_hold_value: assert property (
      @(posedge clk_sys) disable iff (rst)
      (!run && !preload_wr_stopped) |=> cnt_q == $past(cnt_q))
      else $error("counter moved while stopped");

   chk_match_reload_clear: assert property (
      @(posedge clk_sys) disable iff (rst)
      (step && clr_hit && !preload_wr_stopped) |=> (cnt_q == 16'h0000) && (period_q == $past(preload_q)))
      else $error("match tick did not clear counter and reload compare");

   chk_period_flag_set: assert property (
      @(posedge clk_sys) disable iff (rst)
      (step && irq_hit) |=> status_q[0])
      else $error("period request flag not set on its tick");

   chk_source_select: assert property (
      @(posedge clk_sys) disable iff (rst)
      (step && !clear_select && !irq_select && match_period && !overflow) |=> !$rose(status_q[0]))
      else $error("overflow mode raised a request on compare match");

   chk_aux_flag_set: assert property (
      @(posedge clk_sys) disable iff (rst)
      (step && match_aux) |=> status_q[1])
      else $error("aux compare request flag not set");

   chk_snapshot_capture: assert property (
      @(posedge clk_sys) disable iff (rst)
      snap_wr |=> snap_q == $past(cnt_q))
      else $error("snapshot write did not capture the counter");

   chk_zero_as_one: assert property (
      @(posedge clk_sys) disable iff (rst)
      (step && period_q == 16'h0000 && cnt_q == 16'h0001 && clear_select) |=> cnt_q == 16'h0000)
      else $error("compare zero not treated like compare one");

   chk_no_step_stopped: assert property (
      @(posedge clk_sys) disable iff (rst)
      !run |=> !tick)
      else $error("count tick produced while run flag clear");

   chk_irq_follows: assert property (
      @(posedge clk_sys) disable iff (rst)
      (|(status_q & mask_q)) && !(wr_en && (sel_status || sel_mask)) |-> irq_q)
      else $error("interrupt low while an unmasked flag is set");

   chk_ready_after_setup: assert property (
      @(posedge clk_sys) disable iff (rst)
      setup |=> pready_q)
      else $error("no ready in the cycle after setup");

   chk_ready_one_cycle: assert property (
      @(posedge clk_sys) disable iff (rst)
      pready_q |=> !pready_q)
      else $error("ready held longer than one cycle");

   chk_err_unmapped: assert property (
      @(posedge clk_sys) disable iff (rst)
      (setup && !mapped) |=> pslverr_q)
      else $error("unmapped access gave no error response");

   chk_err_mapped: assert property (
      @(posedge clk_sys) disable iff (rst)
      (setup && mapped) |=> !pslverr_q)
      else $error("mapped access gave an error response");

   chk_read_counter: assert property (
      @(posedge clk_sys) disable iff (rst)
      (setup && !pwrite && sel_counter) |=> prdata_q == {16'h0000, $past(cnt_q)})
      else $error("counter read did not return the live count");

   chk_prdata_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      !(setup && !pwrite) |=> prdata_q == $past(prdata_q))
      else $error("read data changed outside a read setup");

   chk_ctrl_write: assert property (
      @(posedge clk_sys) disable iff (rst)
      (wr_en && sel_ctrl && pstrb[0]) |=> ctrl_q == 6'($past(pwdata)))
      else $error("control write did not land");

   chk_status_w1c: assert property (
      @(posedge clk_sys) disable iff (rst)
      (w1c[0] && !events[0]) |=> !status_q[0])
      else $error("write one did not clear the period flag");

   chk_flag_sticky: assert property (
      @(posedge clk_sys) disable iff (rst)
      (status_q[1] && !w1c[1]) |=> status_q[1])
      else $error("aux flag dropped without a clear");

   chk_overflow_wrap: assert property (
      @(posedge clk_sys) disable iff (rst)
      (step && !clear_select && overflow) |=> cnt_q == 16'h0000)
      else $error("overflow tick did not clear the counter");

   chk_irqsel_no_clear: assert property (
      @(posedge clk_sys) disable iff (rst)
      (step && !clear_select && irq_select && match_period && !overflow) |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("match cleared the counter in overflow clear mode");

   chk_period_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      (!step && !preload_wr_stopped) |=> period_q == $past(period_q))
      else $error("period compare changed without reload");

   chk_snap_hold: assert property (
      @(posedge clk_sys) disable iff (rst)
      !snap_wr |=> snap_q == $past(snap_q))
      else $error("snapshot changed without a write");
endmodule : tic_timer16

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
   typedef struct {logic [2:0] src; logic [15:0] ticks;} tic_row_s;
   logic        clk_sys      = 1'b0;
   logic        rst          = 1'b1;
   logic        osc_in       = 1'b0;
   logic        osc_ph       = 1'b0;
   logic        psel         = 1'b0;
   logic        penable      = 1'b0;
   logic        pwrite       = 1'b0;
   logic [7:0]  paddr        = 8'h00;
   logic [31:0] pwdata       = 32'h0;
   logic [3:0]  pstrb        = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic [31:0] rd;
   logic [31:0] c1;
   logic        er;
   int          err_count    = 0;
   int          total_checks = 0;
   int          cyc          = 0;
   int          n0, n1, n5, n9;
   // source code, expected ticks in a 2000-cycle window (osc toggles every 2 cycles)
   tic_row_s    rows [8]     = '{'{3'h0, 16'h01F4}, '{3'h1, 16'h00FA}, '{3'h2, 16'h007D}, '{3'h3, 16'h001F},
                                 '{3'h4, 16'h03E8}, '{3'h5, 16'h01F4}, '{3'h6, 16'h00FA}, '{3'h7, 16'h003E}};
   logic [31:0] rst_val [8]  = '{32'h0, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

   tic_timer16 dut (.clk_sys(clk_sys), .rst(rst), .osc_in(osc_in), .psel(psel), .penable(penable),
                    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
                    .pready(pready), .pslverr(pslverr), .irq(irq));

   always #(tic_pkg::CLK_SYS_PERIOD_NS / 2) clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      osc_ph <= ~osc_ph;
      if (osc_ph) osc_in <= ~osc_in;
   end

   // whole run needs roughly 30000 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      total_checks++;
      if ($isunknown(got) || got < lo || got > hi) begin
         err_count++;
         $display("wrong value at %0t: got %h, want %h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 4'hF);
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      xfer(1'b0, a, 32'h0, 4'h0);
   endtask : rdr

   task automatic wirq(output int n);
      n = 0;
      // irq seen at the call edge may be the value a clear is just removing
      do begin
         @(posedge clk_sys);
         n++;
      end while (irq !== 1'b1 && n < 9000);
      if (n >= 9000) err_count++;
   endtask : wirq

   // pending flags cleared before every start
   task automatic irq_time(input logic [15:0] pre, input logic [31:0] ctl, output int n);
      // half-rate source runs free: fix the start parity so timings compare exactly
      if (cyc % 2 == 1) @(posedge clk_sys);
      wr(tic_pkg::OFF_CTRL, 32'h0);
      wr(tic_pkg::OFF_STATUS, 32'h3);
      wr(tic_pkg::OFF_PRELOAD, 32'(pre));
      wr(tic_pkg::OFF_CTRL, ctl);
      wirq(n);
   endtask : irq_time

   task automatic irq_is(input logic exp);
      repeat (2) @(posedge clk_sys);
      chk(32'(irq), 32'(exp));
   endtask : irq_is

   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rdr(8'(i * 4));
         chk(rd, rst_val[i]);
      end
      foreach (rows[i]) begin
         wr(tic_pkg::OFF_PRELOAD, 32'hFFFF);
         wr(tic_pkg::OFF_CTRL, 32'({rows[i].src, 1'b1}));
         repeat (1997) @(posedge clk_sys);
         wr(tic_pkg::OFF_CTRL, 32'h0);
         rdr(tic_pkg::OFF_COUNTER);
         chk_rng(rd, 32'(rows[i].ticks) - 2, 32'(rows[i].ticks) + 2);
      end
      // match clears, sys clock undivided: one tick every 2 cycles
      wr(tic_pkg::OFF_MASK, 32'h1);
      irq_time(16'h0000, 32'h19, n0);
      irq_time(16'h0001, 32'h19, n1);
      irq_time(16'h0005, 32'h19, n5);
      irq_time(16'h0009, 32'h19, n9);
      chk(32'(n1), 32'(n0));
      chk(32'(n9 - n5), 32'h8);
      rdr(tic_pkg::OFF_PERIOD);
      chk(rd, 32'h9);
      // divided by 16: a write while running must not disturb the count
      irq_time(16'h00C8, 32'h1F, n0);
      repeat (100) @(posedge clk_sys);
      rdr(tic_pkg::OFF_COUNTER);
      c1 = rd;
      wr(tic_pkg::OFF_PRELOAD, 32'h64);
      rdr(tic_pkg::OFF_COUNTER);
      chk_rng(rd, c1, c1 + 1);
      rdr(tic_pkg::OFF_PERIOD);
      chk(rd, 32'hC8);
      wr(tic_pkg::OFF_STATUS, 32'h3);
      wirq(n0);
      rdr(tic_pkg::OFF_PERIOD);
      chk(rd, 32'h64);
      repeat (200) @(posedge clk_sys);
      wr(tic_pkg::OFF_CTRL, 32'h0);
      rdr(tic_pkg::OFF_COUNTER);
      c1 = rd;
      repeat (50) @(posedge clk_sys);
      rdr(tic_pkg::OFF_COUNTER);
      chk(rd, c1);
      wr(tic_pkg::OFF_SNAPSHOT, 32'h1);
      rdr(tic_pkg::OFF_SNAPSHOT);
      chk(rd, c1);
      // low byte lane only, while stopped
      xfer(1'b1, tic_pkg::OFF_PRELOAD, 32'h0000_ABCD, 4'h1);
      rdr(tic_pkg::OFF_COUNTER);
      chk(rd, 32'h0);
      rdr(tic_pkg::OFF_PERIOD);
      chk(rd, 32'hCD);
      // interrupt on match, clear on overflow: counter runs past the compare
      irq_time(16'h0005, 32'h29, n0);
      wr(tic_pkg::OFF_CTRL, 32'h0);
      rdr(tic_pkg::OFF_COUNTER);
      chk_rng(rd, 32'h6, 32'hA);
      // aux match raises its own flag ahead of the period match
      wr(tic_pkg::OFF_AUX, 32'h3);
      wr(tic_pkg::OFF_MASK, 32'h2);
      irq_time(16'h000A, 32'h19, n0);
      rdr(tic_pkg::OFF_STATUS);
      chk(rd, 32'h2);
      repeat (30) @(posedge clk_sys);
      wr(tic_pkg::OFF_CTRL, 32'h0);
      rdr(tic_pkg::OFF_STATUS);
      chk(rd, 32'h3);
      wr(tic_pkg::OFF_MASK, 32'h0);
      irq_is(1'b0);
      wr(tic_pkg::OFF_MASK, 32'h1);
      irq_is(1'b1);
      wr(tic_pkg::OFF_STATUS, 32'h1);
      irq_is(1'b0);
      rdr(tic_pkg::OFF_STATUS);
      chk(rd, 32'h2);
      // unmapped and read-only places
      rdr(8'h40);
      chk(32'(er), 32'h1);
      wr(tic_pkg::OFF_PERIOD, 32'h55);
      chk(32'(er), 32'h0);
      rdr(tic_pkg::OFF_PERIOD);
      chk(rd, 32'hA);
      stop_test();
   end
endmodule : testbench
